// file: ddc_fir_final_shift.v
// back end of the downconverter: decimation phase, fir, final shift, output fifo
`include "ddc_map.vh"
`default_nettype none

// Operation
// RULE_01: 66-tap fixed 21-bit coefficient fir stage
// RULE_02: fir emits one sample per input
// RULE_03: coefficients mirrored, tap k equals 65-k
// RULE_04: fir enable low bypasses fir
// RULE_05: fir only runs behind decimator
// RULE_06: software enables fir for real output
// RULE_07: sync bits pick every or first sync
// RULE_08: accepted sync restarts decimation phase
// RULE_09: far side shares sync across devices
// RULE_10: i and q filtered identically
// RULE_11: mixer shifts up by adc rate/8
// RULE_12: mixer bypass interleaves i and q
// RULE_13: decimator always halves sample rate
// RULE_14: phase bit keeps first or second
// RULE_15: one-shot arming cleared once used
// RULE_16: wide accumulator, rounded to data width
module ddc_fir_final_shift #(
   parameter DW = `DATA_W,
   parameter DEPTH = `FIFO_DEPTH,
   parameter FAW = `FIFO_AW
) (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // complex input stream, full adc rate
   input wire in_valid,
   output reg in_ready_q,
   input wire [DW-1:0] in_i,
   input wire [DW-1:0] in_q,
   // configuration bits
   input wire fir_enable,
   input wire sync_realign_en,
   input wire sync_first_only,
   input wire sync_cfg_wr,
   input wire dec_phase,
   input wire mix_enable,
   // sync pin
   input wire sync_pin,
   // output stream
   output reg out_valid_q,
   input wire out_ready,
   output reg [DW-1:0] out_data_q,
   output reg out_is_q_q,
   // status
   output reg sync_armed_q
);

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------

   // negate with clip, the most negative code has no positive twin
   // saturating instead of wrapping keeps a full-scale negative input
   // from wrapping back to full-scale negative after the shift instead of turning positive
   function [DW-1:0] neg_sat;
      input [DW-1:0] v;
      begin
         if (v == {1'b1, {(DW-1){1'b0}}}) begin
            neg_sat = {1'b0, {(DW-1){1'b1}}};
         end else begin
            neg_sat = ~v + {{(DW-1){1'b0}}, 1'b1};
         end
      end
   endfunction

   // ------------------------------------------------
   // sync pin synchroniser and edge detect
   // ------------------------------------------------
   reg sync_meta_q; // first stage, read only by the second
   reg sync_sync_q; // second stage
   reg sync_prev_q; // previous level for the edge
   wire sync_rise = sync_sync_q & ~sync_prev_q;
   wire sync_take; // this edge realigns the decimator

   // the edge is acted on three clocks after the pin rises; a pulse
   // must stand for at least one clock or the first flop may miss it
   // two flops before anything looks at the pin
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         sync_meta_q <= 1'b0;
         sync_sync_q <= 1'b0;
         sync_prev_q <= 1'b0;
      end else begin
         sync_meta_q <= sync_pin;
         sync_sync_q <= sync_meta_q;
         sync_prev_q <= sync_sync_q;
      end
   end

   // every edge, or only the first after a write while armed [RULE_07] [RULE_15]
   assign sync_take = sync_rise & sync_realign_en & (~sync_first_only | sync_armed_q);

   // arming: a write sets, a used edge clears, a write in the same cycle wins
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         sync_armed_q <= 1'b0;
      end else if (sync_cfg_wr) begin
         sync_armed_q <= 1'b1;
      end else if (sync_take && sync_first_only) begin
         sync_armed_q <= 1'b0; // [RULE_15]
      end
   end

   // ------------------------------------------------
   // decimation by two with selectable phase
   // ------------------------------------------------
   wire in_take = in_valid & in_ready_q; // sample accepted this cycle
   reg hb_cnt_q; // 0 = first sample after sync, 1 = second
   wire hb_cnt = sync_take ? 1'b0 : hb_cnt_q; // a sync restarts the count now
   reg dec_valid_q; // one kept sample per two inputs
   reg [DW-1:0] dec_i_q; // kept i
   reg [DW-1:0] dec_q_q; // kept q

   // limitation: a sync taken while samples stream in, with phase 0,
   // can make two kept samples touch; in interleaved mode the i and q words of
   // the second are then lost, so pause the input around a sync event.
   // a sync with no sample in that cycle simply restarts the count.
   // keep the sample whose position matches the phase bit [RULE_13] [RULE_14]
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         hb_cnt_q <= 1'b0;
         dec_valid_q <= 1'b0;
         dec_i_q <= {DW{1'b0}};
         dec_q_q <= {DW{1'b0}};
      end else begin
         dec_valid_q <= 1'b0;
         if (in_take) begin
            hb_cnt_q <= ~hb_cnt; // [RULE_08]
            if (hb_cnt == dec_phase) begin
               dec_valid_q <= 1'b1;
               dec_i_q <= in_i;
               dec_q_q <= in_q;
            end
         end else if (sync_take) begin
            hb_cnt_q <= 1'b0; // next sample is the first again [RULE_08]
         end
      end
   end

   // ------------------------------------------------
   // fir stage, one instance per component
   // ------------------------------------------------
   // fed only by decimated samples, so it can never run on its own [RULE_05]
   wire fir_feed = dec_valid_q & fir_enable;
   wire fir_i_valid; // filtered i ready
   wire fir_q_valid; // filtered q ready, same timing as i
   wire [DW-1:0] fir_i; // filtered i
   wire [DW-1:0] fir_q; // filtered q

   // identical filters on both components [RULE_10]
   fir66_sym #(
      .DW(DW)
   ) u_fir_i (
      .clk(ref_clk),
      .rst(sys_rst),
      .in_valid(fir_feed),
      .in_data(dec_i_q),
      .out_valid(fir_i_valid),
      .out_data(fir_i)
   );

   fir66_sym #(
      .DW(DW)
   ) u_fir_q (
      .clk(ref_clk),
      .rst(sys_rst),
      .in_valid(fir_feed),
      .in_data(dec_q_q),
      .out_valid(fir_q_valid),
      .out_data(fir_q)
   );

   // switching the bypass while data flows is not glitch-free: words
   // in the fir pipeline at that moment may be lost or repeated
   // bypass hands the decimated sample straight on [RULE_04]
   wire flt_valid = fir_enable ? fir_i_valid : dec_valid_q;
   wire [DW-1:0] flt_i = fir_enable ? fir_i : dec_i_q;
   wire [DW-1:0] flt_q = fir_enable ? fir_q : dec_q_q;

   // ------------------------------------------------
   // final shift and output formatting
   // ------------------------------------------------
   // output runs at half the adc rate, so adc/8 is a quarter turn per sample:
   // real part cycles through i, -q, -i, q
   reg [1:0] mix_step_q; // rotation index
   reg pend_q; // q word still owed in interleaved mode
   reg [DW-1:0] pend_data_q; // the owed q word
   reg wr_valid; // word into the fifo
   reg [DW-1:0] wr_data; // its value
   reg wr_is_q; // marks the q half of a pair
   wire fifo_in_ready; // fifo has room
   reg [DW-1:0] mix_word; // rotated real sample

   // the negative image is only suppressed with the fir in the path, so
   // real output is meant to run with the fir enabled; nothing here
   // forces it, the combination is left to the configuring side
   // real part of the rotated sample [RULE_11]
   always @* begin
      case (mix_step_q)
         2'd0: mix_word = flt_i;
         2'd1: mix_word = neg_sat(flt_q);
         2'd2: mix_word = neg_sat(flt_i);
         2'd3: mix_word = flt_q;
         default: mix_word = flt_i;
      endcase
   end

   // choose what goes into the fifo this cycle
   always @* begin
      wr_valid = 1'b0;
      wr_data = {DW{1'b0}};
      wr_is_q = 1'b0;
      if (pend_q) begin
         wr_valid = 1'b1; // q half of the pair
         wr_data = pend_data_q;
         wr_is_q = 1'b1;
      end else if (flt_valid) begin
         wr_valid = 1'b1;
         wr_data = mix_enable ? mix_word : flt_i; // [RULE_11] [RULE_12]
      end
   end

   // rotation index and the owed q word
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         mix_step_q <= 2'd0;
         pend_q <= 1'b0;
         pend_data_q <= {DW{1'b0}};
      end else begin
         pend_q <= 1'b0;
         if (!pend_q && flt_valid) begin
            if (mix_enable) begin
               mix_step_q <= mix_step_q + 2'd1; // [RULE_11]
            end else begin
               pend_q <= 1'b1; // i now, q next cycle [RULE_12]
               pend_data_q <= flt_q;
            end
         end
      end
   end

   // ------------------------------------------------
   // output fifo and output register
   // ------------------------------------------------
   wire fifo_out_valid; // word waiting
   wire [DW:0] fifo_out_data; // {is_q, data}
   wire [FAW:0] fifo_level; // words held
   wire out_load = ~out_valid_q | out_ready; // output register free
   localparam [FAW:0] READY_LEVEL = `READY_LEVEL;

   sample_fifo #(
      .W(DW + 1),
      .DEPTH(DEPTH),
      .AW(FAW)
   ) u_fifo (
      .clk(ref_clk),
      .rst(sys_rst),
      .in_valid(wr_valid),
      .in_ready(fifo_in_ready),
      .in_data({wr_is_q, wr_data}),
      .out_valid(fifo_out_valid),
      .out_ready(out_load),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   // back-pressure: stop taking input while the fifo lacks room for
   // the words already in flight. ready is registered, so a sample can
   // still be taken one clock after the level crosses the threshold, and
   // with the fir in the path its q word lands four clocks after that.
   // at one word per clock that is up to six words beyond the level seen,
   // so the threshold leaves exactly that much headroom in eight words.
   // a word offered to a full fifo would be dropped, hence the margin.
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         in_ready_q <= 1'b0;
      end else begin
         in_ready_q <= fifo_in_ready && (fifo_level <= READY_LEVEL);
      end
   end

   // the register takes a word whenever it is empty or being taken, so
   // a stalled word stands unchanged with its q flag until accepted
   // output register, so every output leaves from a flop
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         out_valid_q <= 1'b0;
         out_data_q <= {DW{1'b0}};
         out_is_q_q <= 1'b0;
      end else if (out_load) begin
         out_valid_q <= fifo_out_valid;
         if (fifo_out_valid) begin
            out_data_q <= fifo_out_data[DW-1:0];
            out_is_q_q <= fifo_out_data[DW];
         end
      end
   end

endmodule
`default_nettype wire

// file: ddc_map.vh
// constants for the filter back end: widths, depths, bit positions and counts
`ifndef DDC_MAP_VH
`define DDC_MAP_VH

// ------------------------------------------------
// data path widths
// ------------------------------------------------
`define DATA_W 16
`define FIR_TAPS 66
`define FIR_COEF_W 21
`define FIR_COEF_SHIFT 21

// ------------------------------------------------
// control register locations (bits arrive as ports)
// ------------------------------------------------
`define SYNC_CFG_ADDR 12'h0100
`define SYNC_HB_EN_BIT 5
`define SYNC_HB_ONCE_BIT 6
`define FILT_CFG_ADDR 12'h0102
`define FIR_EN_BIT 0
`define HB_CFG_ADDR 12'h0103
`define HB_PHASE_BIT 3

// ------------------------------------------------
// buffering and flow control
// ------------------------------------------------
`define FIFO_DEPTH 8
`define FIFO_AW 3
// highest fifo level at which input is still taken; leaves room for six words in flight
`define READY_LEVEL 2

// ------------------------------------------------
// final shift: quarter turn per output sample
// ------------------------------------------------
`define MIX_STEPS 4

`endif

// file: sample_fifo.v
// small synchronous fifo with valid/ready on both sides
`default_nettype none

module sample_fifo #(
   parameter W = 17,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data,
   // fill level
   output wire [AW:0] level
);

   // ------------------------------------------------
   // storage and pointers
   // ------------------------------------------------
   localparam [AW:0] FULL = DEPTH; // depth must be a power of two
   localparam [AW-1:0] ONE = 1;
   localparam [AW:0] ONE_C = 1;
   reg [W-1:0] mem [0:DEPTH-1]; // word store, no reset needed
   reg [AW-1:0] wr_q; // write pointer
   reg [AW-1:0] rd_q; // read pointer
   reg [AW:0] cnt_q; // words held
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = (cnt_q != FULL);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_q];
   assign level = cnt_q;

   // store the incoming word
   always @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and count
   always @(posedge clk) begin
      if (rst) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + ONE;
         end
         if (pop) begin
            rd_q <= rd_q + ONE;
         end
         case ({push, pop})
            2'b10: cnt_q <= cnt_q + ONE_C;
            2'b01: cnt_q <= cnt_q - ONE_C;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

endmodule
`default_nettype wire

// file: fir66_sym.v
// symmetric 66-tap fixed-coefficient fir, one output per input
`include "ddc_map.vh"
`default_nettype none

module fir66_sym #(
   parameter DW = 16
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // input samples
   input wire in_valid,
   input wire signed [DW-1:0] in_data,
   // filtered samples
   output reg out_valid,
   output reg signed [DW-1:0] out_data
);

   // ------------------------------------------------
   // sizes
   // ------------------------------------------------
   localparam TAPS = `FIR_TAPS;
   localparam HALF = TAPS / 2;
   localparam SH = `FIR_COEF_SHIFT;
   localparam AW = DW + `FIR_COEF_W + 7; // room for the full sum
   localparam signed [AW-1:0] RND = 1 <<< (SH - 1);

   // half of the table; tap k and tap 65-k share it
   function signed [`FIR_COEF_W-1:0] coef;
      input integer k;
      begin
         case (k)
            0: coef = 21'sd383;
            1: coef = 21'sd1431;
            2: coef = 21'sd1950;
            3: coef = 21'sd96;
            4: coef = -21'sd2661;
            5: coef = -21'sd1750;
            6: coef = 21'sd2476;
            7: coef = 21'sd2388;
            8: coef = -21'sd3867;
            9: coef = -21'sd5150;
            10: coef = 21'sd3788;
            11: coef = 21'sd7513;
            12: coef = -21'sd4511;
            13: coef = -21'sd11914;
            14: coef = 21'sd3650;
            15: coef = 21'sd16484;
            16: coef = -21'sd2818;
            17: coef = -21'sd23200;
            18: coef = -21'sd48;
            19: coef = 21'sd30748;
            20: coef = 21'sd3976;
            21: coef = -21'sd41019;
            22: coef = -21'sd11147;
            23: coef = 21'sd53608;
            24: coef = 21'sd21818;
            25: coef = -21'sd71611;
            26: coef = -21'sd40300;
            27: coef = 21'sd98830;
            28: coef = 21'sd74264;
            29: coef = -21'sd152696;
            30: coef = -21'sd161248;
            31: coef = 21'sd337056;
            32: coef = 21'sd922060;
            default: coef = 21'sd0;
         endcase
      end
   endfunction

   reg signed [DW-1:0] tap_q [0:TAPS-1]; // delay line
   reg shifted_q; // delay line moved last cycle
   reg signed [AW-1:0] acc; // full-precision sum
   reg signed [AW-1:0] rnd; // sum plus half an lsb
   reg signed [DW:0] pre; // pre-added pair
   integer i; // delay line index
   integer j; // pair index for the sum, kept apart from the clocked loop

   // delay line moves only on a new sample, so the rate is unchanged [RULE_02]
   always @(posedge clk) begin
      if (rst) begin
         for (i = 0; i < TAPS; i = i + 1) begin
            tap_q[i] <= {DW{1'b0}};
         end
         shifted_q <= 1'b0;
      end else begin
         shifted_q <= in_valid;
         if (in_valid) begin
            tap_q[0] <= in_data;
            for (i = 1; i < TAPS; i = i + 1) begin
               tap_q[i] <= tap_q[i-1];
            end
         end
      end
   end

   // pre-add mirrored taps then one product per pair [RULE_01] [RULE_03]
   always @* begin
      acc = {AW{1'b0}};
      pre = {(DW+1){1'b0}};
      for (j = 0; j < HALF; j = j + 1) begin
         pre = $signed({tap_q[j][DW-1], tap_q[j]}) + $signed({tap_q[TAPS-1-j][DW-1], tap_q[TAPS-1-j]});
         acc = acc + pre * coef(j);
      end
      rnd = acc + RND;
   end

   // round to nearest and clip back to the data width [RULE_16]
   always @(posedge clk) begin
      if (rst) begin
         out_valid <= 1'b0;
         out_data <= {DW{1'b0}};
      end else begin
         out_valid <= shifted_q;
         if (shifted_q) begin
            if (rnd[AW-1] && !(&rnd[AW-1:DW+SH-1])) begin
               out_data <= {1'b1, {(DW-1){1'b0}}};
            end else if (!rnd[AW-1] && (|rnd[AW-1:DW+SH-1])) begin
               out_data <= {1'b0, {(DW-1){1'b1}}};
            end else begin
               out_data <= rnd[DW+SH-1:SH];
            end
         end
      end
   end

endmodule
`default_nettype wire

// file: ddc_fir_final_shift_assertions.sv
// checker for the port behaviour of the filter back end
`default_nettype none
module ddc_fir_final_shift_assertions #(
   parameter DW = 16
) (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // watched ports
   input wire in_ready_q,
   input wire sync_realign_en,
   input wire sync_first_only,
   input wire sync_cfg_wr,
   input wire mix_enable,
   input wire sync_pin,
   input wire out_valid_q,
   input wire out_ready,
   input wire [DW-1:0] out_data_q,
   input wire out_is_q_q,
   input wire sync_armed_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---
   // helper: which half of a pair comes next
   // ---
   logic want_q_q; // next interleaved word should carry q
   // takes the inverse of each accepted word's q flag, so a lost or doubled word shows
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         want_q_q <= 1'b0;
      end else if (out_valid_q && out_ready) begin
         want_q_q <= !out_is_q_q;
      end
   end
   // ---
   // assertions
   // ---
   a_reset_clears_all: assert property (@(posedge ref_clk)
      sys_rst |=> !in_ready_q && !out_valid_q && !sync_armed_q) else $error("reset left outputs active");
   a_ready_after_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> ##[0:1] in_ready_q) else $error("input not ready after reset");
   a_out_word_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
      out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q) && $stable(out_is_q_q))
      else $error("output word changed while stalled");
   a_mix_real_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
      out_valid_q && mix_enable |-> !out_is_q_q) else $error("q flag set in real output");
   a_pair_i_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
      out_valid_q && !mix_enable |-> out_is_q_q == want_q_q) else $error("interleave order broken");
   a_arm_on_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sync_cfg_wr |=> sync_armed_q) else $error("write did not arm");
   a_arm_rise_cause: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $rose(sync_armed_q) |-> $past(sync_cfg_wr)) else $error("armed without write");
   a_arm_used_once: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sync_armed_q && sync_realign_en && sync_first_only && !sync_cfg_wr && $rose(sync_pin)
      |-> ##[1:5] !sync_armed_q) else $error("arming not cleared by sync");
   a_arm_kept_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sync_armed_q && !(sync_realign_en && sync_first_only) |=> sync_armed_q)
      else $error("arming lost without use");
endmodule
bind ddc_fir_final_shift ddc_fir_final_shift_assertions #(.DW(DW)) u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .in_ready_q(in_ready_q), .sync_realign_en(sync_realign_en), .sync_first_only(sync_first_only),
   .sync_cfg_wr(sync_cfg_wr), .mix_enable(mix_enable), .sync_pin(sync_pin), .out_valid_q(out_valid_q),
   .out_ready(out_ready), .out_data_q(out_data_q), .out_is_q_q(out_is_q_q), .sync_armed_q(sync_armed_q));
`default_nettype wire

// file: ddc_out_sink.sv
// far side model: output formatter that stalls at random
`default_nettype none
module ddc_out_sink (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // stream from the block
   input wire logic out_valid_q,
   input wire logic [15:0] out_data_q,
   input wire logic out_is_q_q,
   output logic out_ready,
   // bench control: hold off all words
   input wire logic hold
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [16:0] got[$]; // accepted words, q flag on top
   initial out_ready = 1'b0;
   // take a word on the edge, then pick next ready; a quarter of cycles stall
   always @(posedge ref_clk) begin
      if (!sys_rst && out_valid_q && out_ready) begin
         got.push_back({out_is_q_q, out_data_q});
      end
      #2 out_ready = !hold && ($urandom % 4 != 0);
   end
endmodule
`default_nettype wire

// file: ddc_fir_final_shift_bench.sv
// self-checking bench for the filter back end
`default_nettype none
module ddc_fir_final_shift_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ---
   // stimulus, wiring and reference state
   // ---
   logic ref_clk = 0, sys_rst = 1, in_valid = 0, sync_pin = 0, hold = 0;
   logic fir_enable = 0, sync_realign_en = 0, sync_first_only = 0, sync_cfg_wr = 0, dec_phase = 0, mix_enable = 0;
   logic [15:0] in_i = 0, in_q = 0;
   wire in_ready_q, out_valid_q, out_ready, out_is_q_q, sync_armed_q;
   wire [15:0] out_data_q;
   int c[33] = '{383, 1431, 1950, 96, -2661, -1750, 2476, 2388, -3867, -5150, 3788, 7513, -4511, -11914, 3650,
      16484, -2818, -23200, -48, 30748, 3976, -41019, -11147, 53608, 21818, -71611, -40300, 98830, 74264,
      -152696, -161248, 337056, 922060}; // half of the mirrored taps
   logic signed [15:0] hi[66], hq[66]; // decimated history, newest first
   logic [16:0] expq[$]; // expected words, q flag on top
   int miscompares = 0, checked = 0, pos, step;
   ddc_fir_final_shift u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .in_valid(in_valid), .in_ready_q(in_ready_q),
      .in_i(in_i), .in_q(in_q), .fir_enable(fir_enable), .sync_realign_en(sync_realign_en),
      .sync_first_only(sync_first_only), .sync_cfg_wr(sync_cfg_wr), .dec_phase(dec_phase), .mix_enable(mix_enable),
      .sync_pin(sync_pin), .out_valid_q(out_valid_q), .out_ready(out_ready), .out_data_q(out_data_q),
      .out_is_q_q(out_is_q_q), .sync_armed_q(sync_armed_q));
   ddc_out_sink u_sink (.ref_clk(ref_clk), .sys_rst(sys_rst), .out_valid_q(out_valid_q), .out_data_q(out_data_q),
      .out_is_q_q(out_is_q_q), .out_ready(out_ready), .hold(hold));
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   // ---
   // reference model and helpers
   // ---
   function automatic logic [15:0] sat(longint v);
      return (v > 32767) ? 16'h7fff : (v < -32768) ? 16'h8000 : v[15:0];
   endfunction
   // full-width sum, then round half up back to the sample width
   function automatic logic [15:0] fir(bit sel);
      longint acc;
      acc = 0;
      for (int k = 0; k < 66; k++) acc += longint'(sel ? hq[k] : hi[k]) * c[k < 33 ? k : 65 - k];
      return sat((acc + 64'sh0010_0000) >>> 21);
   endfunction
   task automatic conclude();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(logic [31:0] g, logic [31:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // pushes the words that one kept complex sample must produce
   task automatic keep(logic [15:0] i, logic [15:0] q);
      logic [15:0] v;
      for (int k = 65; k > 0; k--) begin
         hi[k] = hi[k-1];
         hq[k] = hq[k-1];
      end
      hi[0] = i;
      hq[0] = q;
      if (fir_enable) begin
         i = fir(0);
         q = fir(1);
      end
      if (mix_enable) begin
         case (step % 4)
            0: v = i;
            1: v = sat(-longint'($signed(q)));
            2: v = sat(-longint'($signed(i)));
            default: v = q;
         endcase
         step++;
         expq.push_back({1'b0, v});
      end else begin
         expq.push_back({1'b0, i});
         expq.push_back({1'b1, q});
      end
   endtask
   // lowers valid, lets n edges pass, ends just after an edge
   task automatic cyc(int n);
      in_valid = 0;
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   // one attempt: request stands over the edge, ready is a registered level
   task automatic try1(logic [15:0] i, logic [15:0] q, output bit t);
      in_valid = 1;
      in_i = i;
      in_q = q;
      @(negedge ref_clk) t = in_ready_q === 1'b1;
      @(posedge ref_clk) #2;
      if (t) begin
         if (pos == dec_phase) keep(i, q);
         pos = 1 - pos;
      end
   endtask
   task automatic send(logic [15:0] i, logic [15:0] q);
      bit t;
      t = 0;
      for (int n = 0; n < 200 && !t; n++) try1(i, q, t);
      if (!t) begin
         miscompares++;
         $display("Error at %0t: input wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
         conclude();
      end
   endtask
   task automatic start(bit f, bit m, bit ph, bit re, bit fo);
      sys_rst = 1;
      fir_enable = f;
      mix_enable = m;
      dec_phase = ph;
      sync_realign_en = re;
      sync_first_only = fo;
      cyc(16);
      sys_rst = 0;
      foreach (hi[k]) begin
         hi[k] = 0;
         hq[k] = 0;
      end
      pos = 0;
      step = 0;
      cyc(2);
   endtask
   task automatic sync_ev(bit acc);
      cyc(1);
      sync_pin = 1;
      cyc(5);
      sync_pin = 0;
      cyc(3);
      if (acc) pos = 0;
   endtask
   // lets the sink take everything, then compares word by word
   task automatic drain();
      hold = 0;
      cyc(1);
      for (int n = 0; n < 3000 && u_sink.got.size() < expq.size(); n++) cyc(1);
      cyc(20);
      check(u_sink.got.size(), expq.size());
      foreach (expq[k]) if (k < u_sink.got.size()) check(u_sink.got[k], expq[k]);
      u_sink.got.delete();
      expq.delete();
   endtask
   // ---
   // scenarios
   // ---
   initial begin
      bit t;
      logic [15:0] si, sq;
      void'($urandom(46848));
      #2;
      // full-scale impulse on i and q, the other sample of each pair is noise
      for (int ph = 0; ph < 2; ph++) begin
         start(1, 0, ph, 0, 0);
         for (int n = 0; n < 80; n++) begin
            if (ph == 1) send(16'($urandom), 16'($urandom));
            send(n == 0 ? 16'h7fff : 16'h0000, n == 0 ? 16'h8000 : 16'h0000);
            if (ph == 0) send(16'($urandom), 16'($urandom));
         end
         drain();
      end
      // random traffic: bypass, fir interleaved, fir with the final shift
      for (int s = 0; s < 3; s++) begin
         start(s > 0, s == 2, s[0], 0, 0);
         for (int n = 0; n < 40; n++) send(16'($urandom), n == 5 ? 16'h8000 : 16'($urandom));
         drain();
      end
      // far side stalls until the buffer refuses input
      start(0, 0, 1, 0, 0);
      hold = 1;
      t = 1;
      for (int n = 0; n < 30; n++) begin
         if (t) begin
            si = 16'($urandom); // a refused sample is offered again unchanged
            sq = 16'($urandom);
         end
         try1(si, sq, t);
      end
      check(in_ready_q, 0);
      drain();
      // sync ignored, taken on every event, taken once after arming
      for (int m = 0; m < 3; m++) begin
         start(0, 0, 0, m != 0, m == 2);
         if (m == 2) begin
            sync_cfg_wr = 1;
            cyc(1);
            sync_cfg_wr = 0;
            cyc(1);
            check(sync_armed_q, 1);
         end
         send(16'($urandom), 16'($urandom));
         sync_ev(m != 0);
         check(sync_armed_q, 0);
         send(16'($urandom), 16'($urandom));
         sync_ev(m == 1);
         for (int n = 0; n < 12; n++) send(16'($urandom), 16'($urandom));
         drain();
      end
      conclude();
   end
endmodule
`default_nettype wire
